// File: common/tx_err_pkg.sv
// Constants for the transmit error flag and slot counter block.
// Assumes a 32-bit AXI4-Lite register bus and one core clock.
package tx_err_pkg;

    // ************************************************************
    // Bus widths
    // ************************************************************
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int STRB_W = 4;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_SLOT = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_CLEAR = 8'h10;

    // ************************************************************
    // Status, enable and clear layout
    // ************************************************************
    localparam int BIT_UNDERRUN = 0;
    localparam int BIT_EARLY_SYNC = 1;
    localparam int BIT_CLOCK_FAULT = 2;
    localparam int BIT_PARITY = 3;
    localparam int BIT_DMA_OVERWRITE = 7;
    localparam int BIT_ERROR_SUMMARY = 8;
    localparam logic [31:0] ENABLE_MASK = 32'h0000_0087;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

    // ************************************************************
    // Control layout
    // ************************************************************
    localparam int CTRL_LAST_LSB = 0;
    localparam int CTRL_LAST_W = 5;
    localparam int CTRL_BIPHASE = 8;
    localparam int CTRL_RUN = 16;
    localparam logic [31:0] CONTROL_MASK = 32'h0001_011f;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_001f;

    // ************************************************************
    // Slot counter
    // ************************************************************
    localparam int SLOT_W = 10;
    localparam logic [9:0] SLOT_RESET = 10'h17f;
    localparam logic [9:0] BLOCK_LAST_SLOT = 10'h17f;
    localparam int TDM_MAX_SLOTS = 32;

    // ************************************************************
    // Bus responses
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: logic/pin_sync3.sv
// Three-stage synchroniser for a level from outside the core clock.
// Assumes the level is held for at least three core clock cycles.
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,           // Core clock
    input wire logic arst_n,             // Async reset, active low
    input wire logic [WIDTH-1:0] pin_in, // Raw pin level
    output logic [WIDTH-1:0] level       // Filtered level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= (agree & stage3) | (~agree & level);
        end
    end
endmodule // pin_sync3

// File: logic/sticky_flag.sv
// One sticky event flag, set by hardware and cleared by software.
// Assumes set and clear are single-cycle core clock pulses.
`timescale 1ns/10ps
module sticky_flag (
    input wire logic core_clk, // Core clock
    input wire logic arst_n,   // Async reset, active low
    input wire logic set,      // Event pulse
    input wire logic clear,    // Clear pulse
    output logic flag          // Sticky flag
);
    // Set wins so an event in the clearing cycle is kept
    wire next_flag = set | (flag & ~clear);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag <= 1'h0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule // sticky_flag

// File: logic/audio_tx_error_flags_slot_counter.sv
// Transmit error flags, slot counter and their AXI4-Lite registers.
// Assumes slot boundary, buffer write and fault events on core_clk;
// the frame sync arrives from a pin and is synchronised here.
//
// Operation
// - Clock fault event sets clock-fault flag
// - Frame sync before last slot sets flag
// - Transfer from unrefilled holding buffer sets underrun
// - Flags clear only on written one
// - Enabled set flag raises transmit interrupt
// - Slot count readable, ten bits, 0-383
// - Counter holds 383 while held in reset
// - TDM up to 32 slots; 384 in biphase
// - Slot register upper bits zero, writes ignored
// - Error summary is OR of four flags
// - Parity bit shows slot count LSB
`timescale 1ns/10ps
module audio_tx_error_flags_slot_counter (
    input wire logic core_clk,                                // Core clock, 20 MHz
    input wire logic arst_n,                                  // Async reset, active low
    // AXI4-Lite slave
    input wire logic [tx_err_pkg::ADDR_W-1:0] s_axi_awaddr,   // Write address
    input wire logic s_axi_awvalid,                           // Write address valid
    output logic s_axi_awready,                               // Write address ready
    input wire logic [tx_err_pkg::DATA_W-1:0] s_axi_wdata,    // Write data
    input wire logic [tx_err_pkg::STRB_W-1:0] s_axi_wstrb,    // Write strobes
    input wire logic s_axi_wvalid,                            // Write data valid
    output logic s_axi_wready,                                // Write data ready
    output logic [1:0] s_axi_bresp,                           // Write response
    output logic s_axi_bvalid,                                // Write response valid
    input wire logic s_axi_bready,                            // Write response ready
    input wire logic [tx_err_pkg::ADDR_W-1:0] s_axi_araddr,   // Read address
    input wire logic s_axi_arvalid,                           // Read address valid
    output logic s_axi_arready,                               // Read address ready
    output logic [tx_err_pkg::DATA_W-1:0] s_axi_rdata,        // Read data
    output logic [1:0] s_axi_rresp,                           // Read response
    output logic s_axi_rvalid,                                // Read data valid
    input wire logic s_axi_rready,                            // Read data ready
    // Transmit side
    input wire logic tx_frame_sync,                           // Frame sync pin
    input wire logic slot_boundary,                           // Slot boundary pulse
    input wire logic holding_buffer_write,                    // Holding buffer refilled
    input wire logic clock_fault_event,                       // Clock check error pulse
    input wire logic dma_overwrite_event,                     // DMA overwrite pulse
    output logic [tx_err_pkg::SLOT_W-1:0] tx_slot_count,      // Current slot
    output logic tx_buffer_transfer,                          // Buffer moved to shifter
    output logic tx_interrupt                                 // Transmit interrupt
);
    import tx_err_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [31:0] control;
    logic [31:0] enables;
    logic frame_sync_prev;
    logic buffer_loaded;

    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;

    logic frame_sync_level;
    logic tx_underrun_flag;
    logic tx_early_sync_flag;
    logic tx_clock_fault_flag;
    logic tx_dma_overwrite_flag;

    // ************************************************************
    // Control fields
    // ************************************************************
    wire tx_run = control[CTRL_RUN];
    wire biphase_transmit_mode = control[CTRL_BIPHASE];
    wire [CTRL_LAST_W-1:0] frame_last = control[CTRL_LAST_LSB +: CTRL_LAST_W];
    wire [SLOT_W-1:0] tdm_last_slot = {5'h00, frame_last};
    wire [SLOT_W-1:0] last_slot = biphase_transmit_mode
        ? BLOCK_LAST_SLOT
        : tdm_last_slot;

    // ************************************************************
    // Slot counter
    // ************************************************************
    wire slot_advance = tx_run & slot_boundary;
    wire at_last_slot = (tx_slot_count >= last_slot);
    wire [SLOT_W-1:0] slot_plus_one = tx_slot_count + 10'h001;
    wire [SLOT_W-1:0] next_slot = at_last_slot ? 10'h000 : slot_plus_one;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_slot_count <= SLOT_RESET;
        end else if (!tx_run) begin
            tx_slot_count <= SLOT_RESET;
        end else if (slot_advance) begin
            tx_slot_count <= next_slot;
        end
    end

    // ************************************************************
    // Holding buffer tracking
    // ************************************************************
    wire buffer_starved = slot_advance & ~buffer_loaded & ~holding_buffer_write;
    wire next_buffer_loaded = slot_advance ? 1'h0 : (buffer_loaded | holding_buffer_write);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            buffer_loaded <= 1'h0;
            tx_buffer_transfer <= 1'h0;
        end else begin
            buffer_loaded <= next_buffer_loaded;
            tx_buffer_transfer <= slot_advance;
        end
    end

    // ************************************************************
    // Frame sync
    // ************************************************************
    pin_sync3 #(
        .WIDTH(1)
    ) u_fs_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .pin_in(tx_frame_sync),
        .level(frame_sync_level)
    );

    wire frame_sync_edge = frame_sync_level & ~frame_sync_prev;
    // Sync is expected only while the last slot is being sent
    wire sync_early = tx_run & frame_sync_edge & ~at_last_slot;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_sync_prev <= 1'h0;
        end else begin
            frame_sync_prev <= frame_sync_level;
        end
    end

    // ************************************************************
    // Write decode
    // ************************************************************
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire [31:0] wmask = {
        {8{w_strb[3]}},
        {8{w_strb[2]}},
        {8{w_strb[1]}},
        {8{w_strb[0]}}
    };
    wire [31:0] wbits = w_data & wmask;

    wire wr_status = (aw_addr[7:2] == OFS_STATUS[7:2]);
    wire wr_slot = (aw_addr[7:2] == OFS_SLOT[7:2]);
    wire wr_control = (aw_addr[7:2] == OFS_CONTROL[7:2]);
    wire wr_enable = (aw_addr[7:2] == OFS_ENABLE[7:2]);
    wire wr_clear = (aw_addr[7:2] == OFS_CLEAR[7:2]);
    wire wr_mapped = wr_status
        | wr_slot
        | wr_control
        | wr_enable
        | wr_clear;

    wire clear_strobe = do_write & (wr_status | wr_clear);
    wire [31:0] clear_bits = clear_strobe ? wbits : 32'h0000_0000;
    wire [31:0] next_control = (control & ~wmask) | (wbits & CONTROL_MASK);
    wire [31:0] next_enables = (enables & ~wmask) | (wbits & ENABLE_MASK);

    // ************************************************************
    // Error flags
    // ************************************************************
    sticky_flag u_underrun (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set(buffer_starved),
        .clear(clear_bits[BIT_UNDERRUN]),
        .flag(tx_underrun_flag)
    );

    sticky_flag u_early_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set(sync_early),
        .clear(clear_bits[BIT_EARLY_SYNC]),
        .flag(tx_early_sync_flag)
    );

    sticky_flag u_clock_fault (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set(clock_fault_event),
        .clear(clear_bits[BIT_CLOCK_FAULT]),
        .flag(tx_clock_fault_flag)
    );

    sticky_flag u_dma_overwrite (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set(dma_overwrite_event),
        .clear(clear_bits[BIT_DMA_OVERWRITE]),
        .flag(tx_dma_overwrite_flag)
    );

    // ************************************************************
    // Status word and interrupt
    // ************************************************************
    wire tx_error_summary = tx_underrun_flag
        | tx_early_sync_flag
        | tx_clock_fault_flag
        | tx_dma_overwrite_flag;
    wire tx_slot_parity = tx_slot_count[0];

    wire [31:0] status_word = {
        23'h000000,
        tx_error_summary,
        tx_dma_overwrite_flag,
        3'h0,
        tx_slot_parity,
        tx_clock_fault_flag,
        tx_early_sync_flag,
        tx_underrun_flag
    };

    wire [31:0] slot_word = {22'h000000, tx_slot_count};
    wire next_interrupt = |(status_word & enables & ENABLE_MASK);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_interrupt <= 1'h0;
        end else begin
            tx_interrupt <= next_interrupt;
        end
    end

    // ************************************************************
    // Control and enable registers
    // ************************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            control <= CONTROL_RESET;
            enables <= ENABLE_RESET;
        end else if (do_write) begin
            if (wr_control) begin
                control <= next_control;
            end
            if (wr_enable) begin
                enables <= next_enables;
            end
        end
    end

    // ************************************************************
    // AXI write channels
    // ************************************************************
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire b_done = s_axi_bvalid & s_axi_bready;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'h0;
            aw_addr <= '0;
            s_axi_awready <= 1'h1;
        end else if (aw_take) begin
            aw_held <= 1'h1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'h0;
        end else if (b_done) begin
            aw_held <= 1'h0;
            s_axi_awready <= 1'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            w_held <= 1'h0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_wready <= 1'h1;
        end else if (w_take) begin
            w_held <= 1'h1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'h0;
        end else if (b_done) begin
            w_held <= 1'h0;
            s_axi_wready <= 1'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            s_axi_bvalid <= 1'h0;
        end
    end

    // ************************************************************
    // AXI read channels
    // ************************************************************
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire r_done = s_axi_rvalid & s_axi_rready;
    wire rd_status = (s_axi_araddr[7:2] == OFS_STATUS[7:2]);
    wire rd_slot = (s_axi_araddr[7:2] == OFS_SLOT[7:2]);
    wire rd_control = (s_axi_araddr[7:2] == OFS_CONTROL[7:2]);
    wire rd_enable = (s_axi_araddr[7:2] == OFS_ENABLE[7:2]);
    wire rd_clear = (s_axi_araddr[7:2] == OFS_CLEAR[7:2]);
    wire rd_mapped = rd_status
        | rd_slot
        | rd_control
        | rd_enable
        | rd_clear;

    wire [31:0] rd_word;

    // Clear register is write-only and reads as zero
    assign rd_word = rd_status ? status_word
        : rd_slot ? slot_word
        : rd_control ? control
        : rd_enable ? enables
        : 32'h0000_0000;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (r_done) begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid <= 1'h0;
        end
    end

endmodule // audio_tx_error_flags_slot_counter

// File: dv/tx_err_assertions.sv
// Port checker for the transmit error flag and slot counter block.
// Bound to the top module; sees only its ports, one clock domain.
`timescale 1ns/10ps
module tx_err_assertions (
    input wire logic core_clk, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic slot_boundary, // Slot end pulse
    input wire logic [tx_err_pkg::SLOT_W-1:0] tx_slot_count, // Current slot
    input wire logic tx_buffer_transfer, // Buffer moved
    input wire logic tx_interrupt // Transmit interrupt
);
    import tx_err_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ********************
    // Sequences
    // ********************
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_back;
        ##2 s_axi_bvalid;
    endsequence
    // ********************
    // Properties
    // ********************
    a_slot_range: assert property (tx_slot_count <= 10'h17f)
        else $error("slot count out of range");
    a_slot_step: assert property (slot_boundary |=> (tx_slot_count == $past(tx_slot_count) + 10'h1)
        || (tx_slot_count == 10'h0) || (tx_slot_count == SLOT_RESET)) else $error("slot step wrong");
    a_slot_hold: assert property (!slot_boundary |=> $stable(tx_slot_count) || tx_slot_count == SLOT_RESET)
        else $error("slot moved without boundary");
    a_transfer_cause: assert property (tx_buffer_transfer |-> $past(slot_boundary))
        else $error("transfer without boundary");
    a_reset_slot: assert property ($rose(arst_n) |-> tx_slot_count == SLOT_RESET && !tx_interrupt)
        else $error("slot not 383 out of reset");
    a_write_answer: assert property (write_taken |-> resp_back)
        else $error("write response late");
    a_write_ready: assert property (write_taken |=> !s_axi_awready && !s_axi_wready)
        else $error("ready stayed high after take");
    a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("ready not back after response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_irq_fall: assert property ($fell(tx_interrupt) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("interrupt fell without write");
endmodule // tx_err_assertions

bind audio_tx_error_flags_slot_counter tx_err_assertions checker_i (.*);

// File: dv/link_partner.sv
// Far side of the transmit link: slot timing, refills and frame sync.
// Assumes the bench drives its controls on the core clock.
`timescale 1ns/10ps
module link_partner (
    input wire logic core_clk, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic run_link, // Produce slots
    input wire logic refill, // Refill each slot
    input wire logic sync_req, // Raise frame sync
    output logic slot_boundary, // Slot end pulse
    output logic holding_buffer_write, // Refill pulse
    output logic tx_frame_sync // Frame sync pin
);
    logic [1:0] phase;
    // Four-cycle slots, refill mid-slot
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 2'h0;
            slot_boundary <= 1'b0;
            holding_buffer_write <= 1'b0;
            tx_frame_sync <= 1'b0;
        end else begin
            phase <= run_link ? phase + 2'h1 : 2'h0;
            slot_boundary <= run_link && phase == 2'h3;
            holding_buffer_write <= run_link && refill && phase == 2'h1;
            tx_frame_sync <= sync_req;
        end
    end
endmodule // link_partner

// File: dv/testbench.sv
// Self-checking bench for the transmit error flag and slot block.
// Assumes the design package and the link partner are compiled first.
`timescale 1ns/10ps
module testbench;
    import tx_err_pkg::*;
    logic core_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_frame_sync;
    logic slot_boundary, holding_buffer_write, clock_fault_event, dma_overwrite_event;
    logic tx_buffer_transfer, tx_interrupt, run_link, refill, sync_req;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [STRB_W-1:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [SLOT_W-1:0] tx_slot_count;
    int fails, checks;
    audio_tx_error_flags_slot_counter DUT (.*);
    link_partner partner (.*);
    // ********************
    // Shared tasks
    // ********************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end while (!s_axi_bvalid && n < 100);
        check("write resp", {29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, RESP_OKAY});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (!s_axi_rvalid && n < 100);
        check("rvalid", {31'h0, s_axi_rvalid}, 32'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(nm, d & m, e);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge core_clk);
        check("irq", {31'h0, tx_interrupt}, {31'h0, e});
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rdc("status", OFS_STATUS, 32'hffffffff, 32'h00000008);
        rdc("slot", OFS_SLOT, 32'hffffffff, 32'h0000017f);
        rdc("enable", OFS_ENABLE, 32'hffffffff, 32'h00000000);
        w(OFS_SLOT, 32'hffffffff);
        rdc("slot ro", OFS_SLOT, 32'hffffffff, 32'h0000017f);
        rd(8'h14, d, r);
        check("unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
    endtask
    task automatic t_slots(input logic [31:0] ctrl, input int n, input int last);
        int i, k;
        w(OFS_CONTROL, ctrl & 32'h0000ffff);
        w(OFS_CONTROL, ctrl);
        check("slot idle", {22'h0, tx_slot_count}, 32'h0000017f);
        @(posedge core_clk);
        refill <= 1'b1;
        run_link <= 1'b1;
        for (i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge core_clk);
                k++;
            end while (!slot_boundary && k < 10);
            @(negedge core_clk);
            check("transfer", {31'h0, tx_buffer_transfer}, 32'h1);
            check("slot count", {22'h0, tx_slot_count}, 32'(i % (last + 1)));
        end
        @(posedge core_clk);
        run_link <= 1'b0;
        k = (n - 1) % (last + 1);
        rdc("slot reg", OFS_SLOT, 32'hffffffff, 32'(k));
        rdc("parity", OFS_STATUS, 32'h0000000f, 32'(k & 1) << 3);
    endtask
    task automatic t_underrun;
        @(posedge core_clk);
        refill <= 1'b0;
        run_link <= 1'b1;
        repeat (10) @(posedge core_clk);
        run_link <= 1'b0;
        rdc("underrun", OFS_STATUS, 32'h00000107, 32'h00000101);
        w(OFS_ENABLE, 32'h00000001);
        irq_is(1'b1);
        w(OFS_STATUS, 32'h00000000);
        rdc("w0 keeps", OFS_STATUS, 32'h00000001, 32'h00000001);
        w(OFS_STATUS, 32'h00000001);
        rdc("w1 clears", OFS_STATUS, 32'h00000107, 32'h00000000);
        irq_is(1'b0);
    endtask
    task automatic t_faults;
        w(OFS_ENABLE, 32'h00000080);
        @(posedge core_clk) clock_fault_event <= 1'b1;
        @(posedge core_clk) clock_fault_event <= 1'b0;
        irq_is(1'b0);
        rdc("clock fault", OFS_STATUS, 32'h00000187, 32'h00000104);
        @(posedge core_clk) dma_overwrite_event <= 1'b1;
        @(posedge core_clk) dma_overwrite_event <= 1'b0;
        irq_is(1'b1);
        w(OFS_STATUS, 32'h00000080);
        irq_is(1'b0);
        rdc("dma cleared", OFS_STATUS, 32'h00000187, 32'h00000104);
        w(OFS_CLEAR, 32'h00000004);
        rdc("all clear", OFS_STATUS, 32'h00000187, 32'h00000000);
    endtask
    task automatic t_sync;
        w(OFS_ENABLE, 32'h00000002);
        w(OFS_CONTROL, 32'h0001001f);
        @(posedge core_clk);
        refill <= 1'b1;
        run_link <= 1'b1;
        repeat (20) @(posedge core_clk);
        sync_req <= 1'b1;
        repeat (8) @(posedge core_clk);
        sync_req <= 1'b0;
        repeat (8) @(posedge core_clk);
        run_link <= 1'b0;
        irq_is(1'b1);
        rdc("early sync", OFS_STATUS, 32'h00000107, 32'h00000102);
        w(OFS_CLEAR, 32'h00000002);
        irq_is(1'b0);
    endtask
    // ********************
    // Clock, reset, sequence, watchdog
    // ********************
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #1000000;
        fails++;
        final_report();
    end
    initial begin
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {run_link, refill, sync_req, clock_fault_event, dma_overwrite_event} = 5'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        fails = 0;
        checks = 0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_slots(32'h00010003, 6, 3);
        t_slots(32'h0001001f, 33, 31);
        t_slots(32'h0001011f, 385, 383);
        t_underrun();
        t_faults();
        t_sync();
        final_report();
    end
endmodule // testbench
